// *** src/tpcg_defs.svh ***
// timing and encoding constants for the two-phase clock generator
`ifndef TPCG_DEFS_SVH
`define TPCG_DEFS_SVH

`define TPCG_SEQ_PH1    4'h1
`define TPCG_SEQ_GAP1   4'h2
`define TPCG_SEQ_PH2A   4'h4
`define TPCG_SEQ_PH2B   4'h8
`define TPCG_PRE_LAST   2'h3
`define TPCG_ONE        1'b1
`define TPCG_ZERO       1'b0

`endif

// *** src/tpcg_pkg.sv ***
// types for the two-phase clock generator
package tpcg_pkg;

  // =========================================
  // sequencer states
  typedef enum logic [3:0] {
    TPCG_PH1  = 4'h1,
    TPCG_GAP1 = 4'h2,
    TPCG_PH2A = 4'h4,
    TPCG_PH2B = 4'h8
  } tpcg_seq_t;

  // =========================================
  // clock output bundle
  typedef struct packed {
    logic phase1;
    logic phase2;
    logic phase1_ttl;
    logic phase2_ttl;
    logic mem_clk;
    logic double_rate_pulse;
    logic quad_rate_pulse;
    logic memory_data_strobe;
  } tpcg_clk_t;

endpackage

// *** src/tpcg_top.sv ***
// two-phase non-overlapping clock generator core
`timescale 1ns/1ns
`default_nettype none
`include "tpcg_defs.svh"

module tpcg_top
  import tpcg_pkg::*;
#(
  parameter int PRE_W = 2
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // timing source and controls (pins, pulled up outside)
  input  wire logic i_osc_tick,
  input  wire logic i_external_timing_input,
  input  wire logic i_rate_sel,
  input  wire logic i_oscillator_inhibit_n,
  input  wire logic i_refresh_req_n,
  input  wire logic i_mem_ready_n,
  input  wire logic i_manual_reset_input,
  input  wire logic i_manual_reset_input_n,
  input  wire logic i_power_up_timing_low,
  input  wire logic i_power_up_timing_high,
  // clock outputs
  output var tpcg_clk_t o_clk,
  // handshakes and reset
  output logic      o_refresh_grant,
  output logic      o_mem_wait_grant_n,
  output logic      o_reset_n_oe,
  output logic      o_reset_n_out
);

  // =========================================
  // input synchronisers
  localparam int NSYNC = 10;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_out;

  assign raw_in = {i_osc_tick,
                   i_external_timing_input,
                   i_rate_sel,
                   i_oscillator_inhibit_n,
                   i_refresh_req_n,
                   i_mem_ready_n,
                   i_manual_reset_input,
                   i_manual_reset_input_n,
                   i_power_up_timing_low,
                   i_power_up_timing_high};

  // one two-flop synchroniser per pin, reset to the pulled-up level
  for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
    logic s1_q, s1_d;
    logic s2_q, s2_d;

    always_comb begin
      s1_d = raw_in[gi];
      s2_d = s1_q;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        s1_q <= `TPCG_ONE;
        s2_q <= `TPCG_ONE;
      end else begin
        s1_q <= s1_d;
        s2_q <= s2_d;
      end
    end

    assign sync_out[gi] = s2_q;
  end

  // =========================================
  // synchronised control levels
  logic osc_tick;
  logic external_timing_input;
  logic rate_sel;
  logic inh_n;
  logic rreq_n;
  logic mrdy_n;
  logic mr_a;
  logic mr_b;
  logic pu_low;
  logic pu_high;

  assign {osc_tick, external_timing_input, rate_sel, inh_n, rreq_n, mrdy_n,
          mr_a, mr_b, pu_low, pu_high} = sync_out;

  // =========================================
  // source selection and prescaler
  logic             src_q, src_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic             qp_q, qp_d;
  logic             src_rise;
  logic             quad_step;
  logic             quad_rise;

  always_comb begin
    src_d     = rate_sel ? osc_tick : external_timing_input;
    src_rise  = src_d & ~src_q & inh_n;
    pre_d     = pre_q;
    quad_step = `TPCG_ZERO;
    if (src_rise) begin
      if (rate_sel) begin
        pre_d     = pre_q + PRE_W'(1);
        quad_step = &pre_q;
      end else begin
        pre_d     = '0;
        quad_step = `TPCG_ONE;
      end
    end
    // quad pulse: inverted top prescaler bit, or the inverted external input
    if (rate_sel) begin
      qp_d = ~pre_q[PRE_W-1];
    end else begin
      qp_d = ~external_timing_input;
    end
    quad_rise = qp_d & ~qp_q;
  end

  // idle level of the source pins is high, so no false edge after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_q <= `TPCG_ONE;
      pre_q <= '0;
      qp_q  <= `TPCG_ONE;
    end else begin
      src_q <= src_d;
      pre_q <= pre_d;
      qp_q  <= qp_d;
    end
  end

  // =========================================
  // four-state sequencer
  tpcg_seq_t seq_q, seq_d;
  logic      mclk_q, mclk_d;
  logic      mclk_fall;
  logic      wait_n_q, wait_n_d;

  always_comb begin
    seq_d = seq_q;
    if (quad_step) begin
      case (seq_q)
        TPCG_PH1: begin
          seq_d = TPCG_GAP1;
        end
        TPCG_GAP1: begin
          seq_d = TPCG_PH2A;
        end
        TPCG_PH2A: begin
          seq_d = TPCG_PH2B;
        end
        TPCG_PH2B: begin
          seq_d = wait_n_q ? TPCG_PH1 : TPCG_PH2B;
        end
        default: begin
          seq_d = TPCG_PH1;
        end
      endcase
    end
    // memory clock high over the phase two half, unaffected by refresh
    mclk_d    = (seq_d == TPCG_PH2A) || (seq_d == TPCG_PH2B);
    mclk_fall = mclk_q & ~mclk_d;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_q  <= TPCG_PH1;
      mclk_q <= `TPCG_ZERO;
    end else begin
      seq_q  <= seq_d;
      mclk_q <= mclk_d;
    end
  end

  // =========================================
  // refresh and slow-memory handshakes
  logic grant_q, grant_d;

  always_comb begin
    grant_d = grant_q;
    if (mclk_fall) begin
      grant_d = ~rreq_n;
    end
    // the inverted quad pulse falls exactly when the quad pulse rises
    wait_n_d = wait_n_q;
    if (quad_rise) begin
      wait_n_d = mrdy_n;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grant_q  <= `TPCG_ZERO;
      wait_n_q <= `TPCG_ONE;
    end else begin
      grant_q  <= grant_d;
      wait_n_q <= wait_n_d;
    end
  end

  // =========================================
  // reset logic
  logic man_rst_q, man_rst_d;
  logic rst_out_q, rst_out_d;
  logic ph1_rise;

  always_comb begin
    man_rst_d = man_rst_q;
    if (mr_a && !mr_b) begin
      man_rst_d = `TPCG_ONE;
    end else if (!mr_a && mr_b) begin
      man_rst_d = `TPCG_ZERO;
    end
    ph1_rise  = quad_step && (seq_d == TPCG_PH1);
    rst_out_d = rst_out_q;
    if (ph1_rise && (pu_low || man_rst_d)) begin
      rst_out_d = `TPCG_ONE;
    end else if (pu_high && !man_rst_d) begin
      rst_out_d = `TPCG_ZERO;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      man_rst_q <= `TPCG_ZERO;
      rst_out_q <= `TPCG_ONE;
    end else begin
      man_rst_q <= man_rst_d;
      rst_out_q <= rst_out_d;
    end
  end

  // =========================================
  // output registers
  tpcg_clk_t clk_q, clk_d;
  logic      grant_out_q, grant_out_d;
  logic      wait_out_q, wait_out_d;

  // handshake copies are registered with the clocks so they stay in step
  always_comb begin
    clk_d                    = '0;
    clk_d.phase1             = (seq_q == TPCG_PH1) | grant_q;
    clk_d.phase2             = ((seq_q == TPCG_PH2A) | (seq_q == TPCG_PH2B)) & ~grant_q;
    clk_d.phase1_ttl         = clk_d.phase1;
    clk_d.phase2_ttl         = clk_d.phase2;
    clk_d.mem_clk            = mclk_q;
    clk_d.double_rate_pulse  = (seq_q == TPCG_PH1) | (seq_q == TPCG_PH2A);
    clk_d.quad_rate_pulse    = qp_q;
    clk_d.memory_data_strobe = (seq_q == TPCG_PH2B) & ~grant_q;
    grant_out_d              = grant_q;
    wait_out_d               = wait_n_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_q       <= '0;
      grant_out_q <= `TPCG_ZERO;
      wait_out_q  <= `TPCG_ONE;
    end else begin
      clk_q       <= clk_d;
      grant_out_q <= grant_out_d;
      wait_out_q  <= wait_out_d;
    end
  end

  // =========================================
  // port drive
  assign o_clk              = clk_q;
  assign o_refresh_grant    = grant_out_q;
  assign o_mem_wait_grant_n = wait_out_q;
  assign o_reset_n_out      = `TPCG_ZERO;
  assign o_reset_n_oe       = rst_out_q;

endmodule // tpcg_top
`default_nettype wire

// *** verification/tpcg_top_properties.sv ***
// port assertions for the clock generator
`timescale 1ns/1ns
`default_nettype none
module tpcg_top_properties
  import tpcg_pkg::*;
#(parameter int PRE_W = 2) (
  // watched ports
  input wire logic      i_clk,
  input wire logic      i_rst_n,
  input wire logic      i_rate_sel,
  input wire logic      i_external_timing_input,
  input wire logic      i_oscillator_inhibit_n,
  input wire tpcg_clk_t o_clk,
  input wire logic      o_refresh_grant,
  input wire logic      o_mem_wait_grant_n,
  input wire logic      o_reset_n_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ====
  // properties
  property p_gap; !(o_clk.phase1 && o_clk.phase2); endproperty
  a_gap: assert property (p_gap) else $error("phases overlap");
  property p_ttl; {o_clk.phase1_ttl, o_clk.phase2_ttl} == {o_clk.phase1, o_clk.phase2}; endproperty
  a_ttl: assert property (p_ttl) else $error("copy differs");
  property p_frz; o_refresh_grant |-> o_clk.phase1 && !o_clk.phase2; endproperty
  a_frz: assert property (p_frz) else $error("phase not frozen");
  property p_stb; $rose(o_clk.memory_data_strobe) |-> $past(o_clk.phase2, 8); endproperty
  a_stb: assert property (p_stb) else $error("strobe early");
  property p_mck; $rose(o_clk.phase2) |-> $rose(o_clk.mem_clk); endproperty
  a_mck: assert property (p_mck) else $error("mem clock out of step");
  property p_dbl; $rose(o_clk.phase1) |-> o_clk.double_rate_pulse; endproperty
  a_dbl: assert property (p_dbl) else $error("double rate off");
  property p_gnt;
    $changed(o_refresh_grant) |-> !o_clk.mem_clk && $past(o_clk.mem_clk);
  endproperty
  a_gnt: assert property (p_gnt) else $error("grant off mem clock");
  property p_ring;
    (!i_rate_sel && $stable(i_external_timing_input))[*6] |-> o_clk.quad_rate_pulse == !i_external_timing_input;
  endproperty
  a_ring: assert property (p_ring) else $error("quad not inverse");
  property p_inh;
    (!i_oscillator_inhibit_n)[*6] |-> $stable({o_clk.phase1, o_clk.phase2, o_clk.mem_clk,
                                               o_clk.double_rate_pulse,
                                               o_clk.memory_data_strobe});
  endproperty
  a_inh: assert property (p_inh) else $error("clocks move");
  property p_wt; $fell(o_mem_wait_grant_n) |-> $rose(o_clk.quad_rate_pulse); endproperty
  a_wt: assert property (p_wt) else $error("wait off quad");
  c_gnt: cover property ($rose(o_refresh_grant));
  c_wt: cover property ($fell(o_mem_wait_grant_n));
  c_rst: cover property ($rose(o_reset_n_oe));
endmodule // tpcg_top_properties
bind tpcg_top tpcg_top_properties #(.PRE_W(PRE_W)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_rate_sel(i_rate_sel), .i_external_timing_input(i_external_timing_input),
  .i_oscillator_inhibit_n(i_oscillator_inhibit_n), .o_clk(o_clk),
  .o_refresh_grant(o_refresh_grant), .o_mem_wait_grant_n(o_mem_wait_grant_n),
  .o_reset_n_oe(o_reset_n_oe));
`default_nettype wire

// *** verification/tpcg_far_end.sv ***
// timing sources and refresh/memory logic model
`timescale 1ns/1ns
`default_nettype none
module tpcg_far_end (
  // clock and commands
  input  wire logic i_clk,
  input  wire logic i_want_refresh,
  input  wire logic i_want_wait,
  // driven pins
  output logic      o_osc_tick,
  output logic      o_external_timing_input,
  output logic      o_refresh_req_n,
  output logic      o_mem_ready_n
);
  logic [4:0] cnt_q = 5'h00;
  always @(negedge i_clk) begin
    cnt_q <= cnt_q + 5'h01;
  end
  assign o_osc_tick = cnt_q[1];
  assign o_external_timing_input = cnt_q[4];
  assign o_refresh_req_n = !i_want_refresh;
  assign o_mem_ready_n = !i_want_wait;
endmodule // tpcg_far_end
`default_nettype wire

// *** verification/two_phase_clock_generator_test.sv ***
// self-checking bench for the clock generator
`timescale 1ns/1ns
`default_nettype none
module two_phase_clock_generator_test;
  import tpcg_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, rate_sel = 1'b1, inh_n = 1'b1;
  logic       want_ref = 1'b0, want_wait = 1'b0, mr_a = 1'b0, mr_b = 1'b1;
  logic       pu_low = 1'b0, pu_high = 1'b1, osc, ext, req_n, rdy_n, grant, wait_n, oe, rst_out;
  tpcg_clk_t  ck;
  logic [7:0] n;
  logic [7:0] rows [2][4] = '{'{8'h01, 8'h40, 8'h20, 8'h10}, '{8'h00, 8'h80, 8'h40, 8'h20}};
  int         fails = 0, checks_done = 0;
  wire logic [10:0] st = {ck, grant, wait_n, oe};
  tpcg_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_osc_tick(osc), .i_external_timing_input(ext),
    .i_rate_sel(rate_sel), .i_oscillator_inhibit_n(inh_n), .i_refresh_req_n(req_n),
    .i_mem_ready_n(rdy_n), .i_manual_reset_input(mr_a), .i_manual_reset_input_n(mr_b),
    .i_power_up_timing_low(pu_low), .i_power_up_timing_high(pu_high), .o_clk(ck),
    .o_refresh_grant(grant), .o_mem_wait_grant_n(wait_n), .o_reset_n_oe(oe),
    .o_reset_n_out(rst_out));
  tpcg_far_end far_u (.i_clk(clk), .i_want_refresh(want_ref), .i_want_wait(want_wait),
    .o_osc_tick(osc), .o_external_timing_input(ext), .o_refresh_req_n(req_n),
    .o_mem_ready_n(rdy_n));
  // ====
  // tasks
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic wt(input int b, input logic v);
    int k;
    k = 0;
    while (st[b] !== v && k < 600) begin
      @(negedge clk);
      k++;
    end
    chk(11'(st[b]), 11'(v));
  endtask
  task automatic per(input int b, output logic [7:0] c);
    int k;
    k = 0;
    c = 8'h00;
    for (int p = 0; p < 4; p++) begin
      while (st[b] !== p[0] && k < 900) begin
        @(negedge clk);
        k++;
        c = c + 8'(p / 2);
      end
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ====
  // sequence
  initial forever #5 clk = ~clk;
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge clk);
    chk(st, 11'h003);
    chk(11'(rst_out), 11'h000);
    rst_n = 1'b1;
    wt(0, 1'b0);
    for (int r = 0; r < 2; r++) begin
      rate_sel = rows[r][0][0];
      repeat (40) @(negedge clk);
      per(10, n);
      chk(11'(n), 11'(rows[r][1]));
      per(5, n);
      chk(11'(n), 11'(rows[r][2]));
      per(4, n);
      chk(11'(n), 11'(rows[r][3]));
    end
    rate_sel = 1'b1;
    inh_n = 1'b0;
    repeat (8) @(negedge clk);
    n = ck;
    repeat (40) @(negedge clk);
    chk(11'(ck), 11'(n));
    inh_n = 1'b1;
    want_ref = 1'b1;
    wt(2, 1'b1);
    repeat (40) @(negedge clk);
    chk(11'(st[10:9]), 11'h002);
    per(6, n);
    chk(11'(n), 11'h040);
    want_ref = 1'b0;
    wt(2, 1'b0);
    want_wait = 1'b1;
    wt(1, 1'b0);
    repeat (80) @(negedge clk);
    chk(11'({ck.phase2, ck.mem_clk, ck.memory_data_strobe}), 11'h007);
    want_wait = 1'b0;
    wt(1, 1'b1);
    pu_high = 1'b0;
    pu_low = 1'b1;
    wt(0, 1'b1);
    pu_low = 1'b0;
    pu_high = 1'b1;
    wt(0, 1'b0);
    mr_a = 1'b1;
    mr_b = 1'b0;
    wt(0, 1'b1);
    mr_b = 1'b1;
    repeat (20) @(negedge clk);
    chk(11'(oe), 11'h001);
    mr_a = 1'b0;
    wt(0, 1'b0);
    report_and_stop();
  end
endmodule // two_phase_clock_generator_test
`default_nettype wire
